// ==== src/sfrb_consts.vh ====
// Constants of the special function register bank
`ifndef SFRB_CONSTS_VH
`define SFRB_CONSTS_VH
// Byte addresses inside the 4-bit SPECIAL_FUNCTION_REGS space
`define SFRB_ADDR_IE1 4'h0
`define SFRB_ADDR_IE2 4'h1
`define SFRB_ADDR_IFG1 4'h2
`define SFRB_ADDR_IFG2 4'h3
`define SFRB_ADDR_ME1 4'h4
`define SFRB_ADDR_ME2 4'h5
// Bit positions, first enable and flag registers
`define SFRB_BIT_WDOG 0
`define SFRB_BIT_OSCF 1
`define SFRB_BIT_NMI 4
`define SFRB_BIT_FVIOL 5
// Bit positions, second registers and module enables
`define SFRB_BIT_RX 0
`define SFRB_BIT_TX 1
`define SFRB_BIT_ASYNC_RX 0
`define SFRB_BIT_ASYNC_TX 1
`define SFRB_BIT_SYNC 2
// Implemented-bit masks
`define SFRB_MASK_IE1 8'h33
`define SFRB_MASK_IFG1 8'h13
`define SFRB_MASK_IE2 8'h03
`define SFRB_MASK_IFG2 8'h03
`define SFRB_MASK_ME2 8'h07
// Reset values
`define SFRB_RST_IE 8'h00
`define SFRB_RST_IFG2 8'h02
`define SFRB_RST_ME 8'h00
`endif

// ==== src/sfrb_irq_req.v ====
// Flag and enable pairing into interrupt requests
`timescale 1ns/10ps
`default_nettype none
module sfrb_irq_req (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [7:0] flag1,
    input wire [7:0] enable1,
    input wire [7:0] flag2,
    input wire [7:0] enable2,
    input wire wdogIntervalMode,
    output reg wdogReq,
    output reg nmiGroupReq,
    output reg rxReq,
    output reg txReq
);
`include "sfrb_consts.vh"
    always @(posedge clk) begin
        if (rst) begin
            wdogReq <= 1'b0;
            nmiGroupReq <= 1'b0;
            rxReq <= 1'b0;
            txReq <= 1'b0;
        end else if (ce) begin
            // Request held low in restart mode, whatever the enable
            wdogReq <= flag1[`SFRB_BIT_WDOG] & enable1[`SFRB_BIT_WDOG] & wdogIntervalMode;
            // Output is not gated by the global enable
            nmiGroupReq <= (flag1[`SFRB_BIT_NMI] & enable1[`SFRB_BIT_NMI]) |
                           (flag1[`SFRB_BIT_OSCF] & enable1[`SFRB_BIT_OSCF]);
            rxReq <= flag2[`SFRB_BIT_RX] & enable2[`SFRB_BIT_RX];
            txReq <= flag2[`SFRB_BIT_TX] & enable2[`SFRB_BIT_TX];
        end
    end
endmodule // sfrb_irq_req
`default_nettype wire

// ==== src/sfrb_bank.v ====
// Special function register bank, top level
`timescale 1ns/10ps
`default_nettype none
module sfrb_bank (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire porRst,
    input wire pinRst,
    input wire [3:0] addr,
    input wire wrEn,
    input wire rdEn,
    input wire [7:0] wrData,
    output reg [7:0] rdData,
    input wire wdogOverflow,
    input wire wdogKeyViolation,
    input wire wdogIntervalMode,
    input wire oscFault,
    input wire nmiEvent,
    input wire flashViolation,
    input wire serialRxEvent,
    input wire serialTxEvent,
    output reg wdogIrqEn,
    output reg flashViolationIrqEn,
    output reg asyncRxModuleEn,
    output reg asyncTxModuleEn,
    output reg syncModuleEn,
    output wire wdogReq,
    output wire nmiGroupReq,
    output reg flashViolationReq,
    output wire serialRxReq,
    output wire serialTxReq
);
`include "sfrb_consts.vh"
    // ************************************************
    // Storage
    // ************************************************
    reg [7:0] enable1;
    reg [7:0] enable2;
    // Watchdog flag and the rest of the first flag register are separate
    // flops, each with exactly one driver
    reg wdogFlag;
    reg [6:0] flag1Hi;
    wire [7:0] flag1;
    wire [7:0] maskedFlag1;
    reg [7:0] flag2;
    reg [7:0] moduleEn2;
    reg [7:0] next_flag1;
    reg [7:0] next_flag2;
    wire wr1;
    wire wr2;
    wire wrE1;
    wire wrE2;
    wire wrM2;
    assign wr1 = wrEn && (addr == `SFRB_ADDR_IFG1);
    assign wr2 = wrEn && (addr == `SFRB_ADDR_IFG2);
    assign wrE1 = wrEn && (addr == `SFRB_ADDR_IE1);
    assign wrE2 = wrEn && (addr == `SFRB_ADDR_IE2);
    assign wrM2 = wrEn && (addr == `SFRB_ADDR_ME2);
    assign flag1 = {flag1Hi, wdogFlag};
    assign maskedFlag1 = next_flag1 & `SFRB_MASK_IFG1;

    // ************************************************
    // Flag next state, set wins over software write
    // ************************************************
    always @* begin
        next_flag1 = flag1;
        next_flag2 = flag2;
        if (wr1) begin
            next_flag1 = wrData & `SFRB_MASK_IFG1;
        end
        if (wr2) begin
            next_flag2 = wrData & `SFRB_MASK_IFG2;
        end
        if (wdogOverflow && !wdogIntervalMode) begin
            next_flag1[`SFRB_BIT_WDOG] = 1'b1;
        end
        if (wdogKeyViolation) begin
            next_flag1[`SFRB_BIT_WDOG] = 1'b1;
        end
        if (oscFault) begin
            next_flag1[`SFRB_BIT_OSCF] = 1'b1;
        end
        if (nmiEvent) begin
            next_flag1[`SFRB_BIT_NMI] = 1'b1;
        end
        if (serialRxEvent) begin
            next_flag2[`SFRB_BIT_RX] = 1'b1;
        end
        if (serialTxEvent) begin
            next_flag2[`SFRB_BIT_TX] = 1'b1;
        end
    end

    // ************************************************
    // Watchdog flag survives the clear reset
    // ************************************************
    // Reset only by power-on or pin reset, so a watchdog restart stays visible
    always @(posedge clk) begin
        if (porRst || pinRst) begin
            wdogFlag <= 1'b0;
        end else if (ce) begin
            wdogFlag <= next_flag1[`SFRB_BIT_WDOG];
        end
    end

    // ************************************************
    // Clear-reset registers
    // ************************************************
    always @(posedge clk) begin
        if (rst || porRst) begin
            enable1 <= `SFRB_RST_IE;
            enable2 <= `SFRB_RST_IE;
            flag1Hi <= 7'h00;
            flag2 <= `SFRB_RST_IFG2;
            moduleEn2 <= `SFRB_RST_ME;
        end else if (ce) begin
            flag1Hi <= maskedFlag1[7:1];
            flag2 <= next_flag2 & `SFRB_MASK_IFG2;
            if (wrE1) begin
                enable1 <= wrData & `SFRB_MASK_IE1;
            end
            if (wrE2) begin
                enable2 <= wrData & `SFRB_MASK_IE2;
            end
            if (wrM2) begin
                moduleEn2 <= wrData & `SFRB_MASK_ME2;
            end
        end
    end

    // ************************************************
    // Read port and registered outputs
    // ************************************************
    always @(posedge clk) begin
        if (rst || porRst) begin
            rdData <= 8'h00;
            wdogIrqEn <= 1'b0;
            flashViolationIrqEn <= 1'b0;
            asyncRxModuleEn <= 1'b0;
            asyncTxModuleEn <= 1'b0;
            syncModuleEn <= 1'b0;
            flashViolationReq <= 1'b0;
        end else if (ce) begin
            // Unmapped and missing bits read zero
            if (!rdEn) begin
                rdData <= 8'h00;
            end else if (addr == `SFRB_ADDR_IE1) begin
                rdData <= enable1;
            end else if (addr == `SFRB_ADDR_IE2) begin
                rdData <= enable2;
            end else if (addr == `SFRB_ADDR_IFG1) begin
                rdData <= flag1;
            end else if (addr == `SFRB_ADDR_IFG2) begin
                rdData <= flag2;
            end else if (addr == `SFRB_ADDR_ME2) begin
                rdData <= moduleEn2;
            end else begin
                rdData <= 8'h00;
            end
            wdogIrqEn <= enable1[`SFRB_BIT_WDOG] & wdogIntervalMode;
            flashViolationIrqEn <= enable1[`SFRB_BIT_FVIOL];
            // Violation flag lives in the flash module, only its enable here
            flashViolationReq <= flashViolation & enable1[`SFRB_BIT_FVIOL];
            asyncRxModuleEn <= moduleEn2[`SFRB_BIT_ASYNC_RX];
            asyncTxModuleEn <= moduleEn2[`SFRB_BIT_ASYNC_TX];
            syncModuleEn <= moduleEn2[`SFRB_BIT_SYNC];
        end
    end

    // ************************************************
    // Interrupt requests
    // ************************************************
    sfrb_irq_req reqs (
        .clk(clk),
        .rst(rst || porRst),
        .ce(ce),
        .flag1(flag1),
        .enable1(enable1),
        .flag2(flag2),
        .enable2(enable2),
        .wdogIntervalMode(wdogIntervalMode),
        .wdogReq(wdogReq),
        .nmiGroupReq(nmiGroupReq),
        .rxReq(serialRxReq),
        .txReq(serialTxReq)
    );
endmodule // sfrb_bank
`default_nettype wire

// ==== testbench/sfrb_chk.sv ====
// Port-level checker for the special function register bank
`timescale 1ns/10ps
`default_nettype none
module sfrb_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic porRst,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdData,
    input wire logic wdogIntervalMode,
    input wire logic flashViolation,
    input wire logic wdogIrqEn,
    input wire logic flashViolationIrqEn,
    input wire logic asyncRxModuleEn,
    input wire logic asyncTxModuleEn,
    input wire logic syncModuleEn,
    input wire logic wdogReq,
    input wire logic flashViolationReq
);
    // ****
    // Properties
    // ****
    logic [7:0] rdMask;
    always_ff @(posedge clk) begin
        rdMask <= (addr == 4'h0) ? 8'h33 : (addr == 4'h2) ? 8'h13 : (addr == 4'h5) ? 8'h07 :
            (addr == 4'h1 || addr == 4'h3) ? 8'h03 : 8'h00;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst || porRst);
    sequence s_fv_armed;
        ce && flashViolation && flashViolationIrqEn && !wrEn;
    endsequence
    sequence s_wr_me;
        ce && wrEn && addr == 4'h5 ##1 ce;
    endsequence
    sequence s_wr_ie;
        ce && wrEn && addr == 4'h0 ##1 ce;
    endsequence
    a_rd_idle: assert property (ce && !rdEn |=> rdData == 8'h00) else $error("read data not idle");
    a_rd_mask: assert property (ce && rdEn |=> (rdData & ~rdMask) == 8'h00) else $error("absent bit read");
    a_rd_stands: assert property (!ce |=> $stable(rdData)) else $error("read data moved");
    a_wdog_mode: assert property (ce && !wdogIntervalMode |=> !wdogReq) else $error("watchdog req");
    a_wdog_en: assert property (wdogReq |-> wdogIrqEn) else $error("watchdog req unenabled");
    a_fv_cause: assert property (flashViolationReq && $past(ce) |-> flashViolationIrqEn && $past(flashViolation))
        else $error("violation req without cause");
    a_fv_rise: assert property (s_fv_armed ##1 s_fv_armed |=> flashViolationReq) else $error("violation req lost");
    a_me_write: assert property (s_wr_me |=> {syncModuleEn, asyncTxModuleEn, asyncRxModuleEn} == $past(wrData[2:0], 2))
        else $error("module enables wrong");
    a_ie_write: assert property (s_wr_ie |=> {flashViolationIrqEn, wdogIrqEn} ==
        {$past(wrData[5], 2), $past(wrData[0], 2) & $past(wdogIntervalMode)})
        else $error("enable outputs wrong");
endmodule // sfrb_chk
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the special function register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst = 1'b1, porRst = 1'b1, pinRst = 1'b0, ce = 1'b1;
    logic wrEn = 1'b0, rdEn = 1'b0, mode = 1'b0, fv = 1'b0;
    logic [3:0] addr = 4'h0, ra;
    logic [7:0] wrData = 8'h00, rv;
    logic [5:0] evts = 6'h00;
    logic [7:0] evExp [6] = '{8'h01, 8'h01, 8'h02, 8'h10, 8'h01, 8'h02};
    wire [7:0] rdData;
    wire wdogIrqEn, fvIrqEn, rxMe, txMe, syncMe, wdogReq, nmiReq, fvReq, rxReq, txReq;
    int fail_count = 0, checks_done = 0, seedDummy;
    always #50 clk = ~clk;
    sfrb_bank dut (.clk(clk), .rst(rst), .ce(ce), .porRst(porRst), .pinRst(pinRst), .addr(addr), .wrEn(wrEn),
        .rdEn(rdEn), .wrData(wrData), .rdData(rdData), .wdogOverflow(evts[0]), .wdogKeyViolation(evts[1]),
        .wdogIntervalMode(mode), .oscFault(evts[2]), .nmiEvent(evts[3]), .flashViolation(fv),
        .serialRxEvent(evts[4]), .serialTxEvent(evts[5]), .wdogIrqEn(wdogIrqEn), .flashViolationIrqEn(fvIrqEn),
        .asyncRxModuleEn(rxMe), .asyncTxModuleEn(txMe), .syncModuleEn(syncMe), .wdogReq(wdogReq),
        .nmiGroupReq(nmiReq), .flashViolationReq(fvReq), .serialRxReq(rxReq), .serialTxReq(txReq));
    // ****
    // Tasks
    // ****
    function automatic logic [7:0] maskOf(input logic [3:0] a);
        return (a == 4'h0) ? 8'h33 : (a == 4'h2) ? 8'h13 : (a == 4'h5) ? 8'h07 : (a == 4'h1 || a == 4'h3) ? 8'h03 : 8'h00;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wrEn <= 1'b1;
        addr <= a;
        wrData <= d;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rdEn <= 1'b1;
        addr <= a;
        @(posedge clk);
        rdEn <= 1'b0;
        #1 chk(rdData, exp);
    endtask
    task automatic ev(input int i);
        @(posedge clk);
        evts[i] <= 1'b1;
        @(posedge clk);
        evts <= 6'h00;
    endtask
    task automatic tick();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Generous span: the whole sequence needs well under a thousand cycles
    initial begin
        #500000;
        fail_count++;
        close_out();
    end
    initial begin
        seedDummy = $urandom(32'h0388);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        porRst <= 1'b0;
        for (int a = 0; a < 8; a++) rd(a[3:0], (a == 3) ? 8'h02 : 8'h00);
        rd(4'hF, 8'h00);
        @(posedge clk);
        ce <= 1'b0;
        // A write while frozen must leave no trace
        wr(4'h0, 8'h33);
        ce <= 1'b1;
        rd(4'h0, 8'h00);
        $display("test reset values done");
        for (int n = 0; n < 24; n++) begin
            ra = 4'($urandom_range(7));
            rv = 8'($urandom);
            wr(ra, rv);
            rd(ra, rv & maskOf(ra));
        end
        wr(4'h5, 8'h05);
        tick();
        chk({5'h00, syncMe, txMe, rxMe}, 8'h05);
        $display("test random access done");
        for (int i = 0; i < 6; i++) begin
            wr(4'h2, 8'h00);
            wr(4'h3, 8'h00);
            ev(i);
            rd((i < 4) ? 4'h2 : 4'h3, evExp[i]);
        end
        // Event and write-clear in one cycle: the event must win
        @(posedge clk);
        evts <= 6'h08;
        wrEn <= 1'b1;
        addr <= 4'h2;
        wrData <= 8'h00;
        @(posedge clk);
        evts <= 6'h00;
        wrEn <= 1'b0;
        rd(4'h2, 8'h10);
        @(posedge clk);
        mode <= 1'b1;
        wr(4'h2, 8'h00);
        ev(0);
        rd(4'h2, 8'h00);
        ev(1);
        rd(4'h2, 8'h01);
        $display("test event flags done");
        wr(4'h0, 8'h33);
        wr(4'h1, 8'h03);
        wr(4'h2, 8'h13);
        wr(4'h3, 8'h03);
        @(posedge clk);
        fv <= 1'b1;
        tick();
        chk({3'h0, wdogReq, nmiReq, fvReq, rxReq, txReq}, 8'h1F);
        chk({6'h00, fvIrqEn, wdogIrqEn}, 8'h03);
        @(posedge clk);
        mode <= 1'b0;
        fv <= 1'b0;
        wr(4'h3, 8'h00);
        wr(4'h2, 8'h03);
        tick();
        chk({3'h0, wdogReq, nmiReq, fvReq, rxReq, txReq}, 8'h08);
        chk({6'h00, fvIrqEn, wdogIrqEn}, 8'h02);
        wr(4'h0, 8'h10);
        tick();
        chk({7'h00, nmiReq}, 8'h00);
        $display("test requests done");
        wr(4'h2, 8'h01);
        wr(4'h3, 8'h00);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(4'h2, 8'h01);
        rd(4'h3, 8'h02);
        @(posedge clk);
        pinRst <= 1'b1;
        @(posedge clk);
        pinRst <= 1'b0;
        rd(4'h2, 8'h00);
        $display("test resets done");
        close_out();
    end
endmodule // tb_top
bind sfrb_bank sfrb_chk chk (.clk(clk), .rst(rst), .porRst(porRst), .ce(ce), .addr(addr), .wrEn(wrEn),
    .rdEn(rdEn), .wrData(wrData), .rdData(rdData), .wdogIntervalMode(wdogIntervalMode),
    .flashViolation(flashViolation), .wdogIrqEn(wdogIrqEn), .flashViolationIrqEn(flashViolationIrqEn),
    .asyncRxModuleEn(asyncRxModuleEn), .asyncTxModuleEn(asyncTxModuleEn), .syncModuleEn(syncModuleEn),
    .wdogReq(wdogReq), .flashViolationReq(flashViolationReq));
`default_nettype wire
